// >>> apm_pin_mux_regs.vh
// Register map, field layout and selector codes of the pin mux block
`ifndef APM_PIN_MUX_REGS_VH
`define APM_PIN_MUX_REGS_VH

// ****************************************************
// Register indices (byte address is four times index)
// ****************************************************
`define APM_IDX_PIN_DIR 8'h60
`define APM_IDX_PIN1_SEL 8'h62
`define APM_IDX_PIN2_SEL 8'h63
`define APM_IDX_IN_ROUTE 8'h64
`define APM_IDX_OUT_VAL 8'h65
`define APM_IDX_OUT_INV 8'h66
`define APM_IDX_IDENT 8'h67
`define APM_IDX_IRQ_STAT 8'h70
`define APM_IDX_IRQ_MASK 8'h71

// ****************************************************
// Reset values
// ****************************************************
`define APM_RST_BYTE 8'h00

// ****************************************************
// Field positions
// ****************************************************
`define APM_SEL_HI 3
`define APM_SEL_LO 0
`define APM_MISO_HI 7
`define APM_MISO_LO 6
`define APM_SYNC_HI 5
`define APM_SYNC_LO 4
`define APM_RSTSRC_HI 3
`define APM_RSTSRC_LO 2
`define APM_MUTESRC_HI 1
`define APM_MUTESRC_LO 0

// ****************************************************
// Input route codes
// ****************************************************
`define APM_ROUTE_NONE 2'h0
`define APM_ROUTE_PIN0 2'h1
`define APM_ROUTE_PIN1 2'h2
`define APM_ROUTE_PIN2 2'h3

// ****************************************************
// Output function codes
// ****************************************************
`define APM_FN_OFF 4'h0
`define APM_FN_SWVAL 4'h2
`define APM_FN_AMUTE_BOTH 4'h3
`define APM_FN_AMUTE_L 4'h4
`define APM_FN_AMUTE_R 4'h5
`define APM_FN_CLK_BAD 4'h6
`define APM_FN_WARN 4'h8
`define APM_FN_SER_OUT 4'h9
`define APM_FN_SPI_CLK 4'hb
`define APM_FN_SPI_MOSI 4'hd

// ****************************************************
// Interrupt status bits
// ****************************************************
`define APM_IRQ_MUTE 0
`define APM_IRQ_RESET 1
`define APM_IRQ_CLKBAD 2
`define APM_IRQ_W 3

`endif

// >>> apm_pin_mux.v
// General-purpose pin mux with Wishbone register slave and interrupt
`timescale 1ns/1ns
`include "apm_pin_mux_regs.vh"

module apm_pin_mux #(
    parameter ADR_W = 10,
    // Arbitrary identification value, not tied to any part
    parameter [7:0] IDENT_VALUE = 8'h5a
) (
    input wire clk_sys,
    input wire rst_n,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [ADR_W-1:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire [2:0] pinIn,
    output reg [2:0] pinOut_r,
    output reg [2:0] pinOe_r,
    input wire autoMuteLeft,
    input wire autoMuteRight,
    input wire clockError,
    input wire clockMissing,
    input wire warning_out_n,
    input wire serial_audio_out,
    input wire spiClk,
    input wire spiMosi,
    output reg spiMisoIn_r,
    output reg phaseSyncIn_r,
    output reg extReset_r,
    output reg mute_in_n_r,
    output reg driverHiZ_r,
    output reg switchStop_r,
    output reg irq_r
);

    // ****************************************************
    // Helper functions
    // ****************************************************
    // Pin chosen by a two-bit source field, with idle level for none
    function routePick;
        input [1:0] src;
        input [2:0] pins;
        input idle;
        begin
            case (src)
                `APM_ROUTE_PIN0: routePick = pins[0];
                `APM_ROUTE_PIN1: routePick = pins[1];
                `APM_ROUTE_PIN2: routePick = pins[2];
                default: routePick = idle;
            endcase
        end
    endfunction

    // Output function of one pin before inversion
    function pinFunc;
        input [3:0] sel;
        input swVal;
        input amL;
        input amR;
        input clkBad;
        input warnN;
        input sdo;
        input sck;
        input mosi;
        begin
            case (sel)
                `APM_FN_OFF: pinFunc = 1'b0;
                `APM_FN_SWVAL: pinFunc = swVal;
                `APM_FN_AMUTE_BOTH: pinFunc = amL & amR;
                `APM_FN_AMUTE_L: pinFunc = amL;
                `APM_FN_AMUTE_R: pinFunc = amR;
                `APM_FN_CLK_BAD: pinFunc = clkBad;
                `APM_FN_WARN: pinFunc = warnN;
                `APM_FN_SER_OUT: pinFunc = sdo;
                `APM_FN_SPI_CLK: pinFunc = sck;
                `APM_FN_SPI_MOSI: pinFunc = mosi;
                // Reserved codes park low, no glitch on odd writes
                default: pinFunc = 1'b0;
            endcase
        end
    endfunction

    // Register index match, shared by every write strobe
    function regHit;
        input [7:0] idx;
        input [7:0] want;
        begin
            regHit = (idx == want);
        end
    endfunction

    // ****************************************************
    // Registers
    // ****************************************************
    reg [7:0] pinDir_r;
    reg [7:0] pin1Sel_r;
    reg [7:0] pin2Sel_r;
    reg [7:0] inRoute_r;
    reg [7:0] outVal_r;
    reg [7:0] outInv_r;
    reg [`APM_IRQ_W-1:0] irqStat_r;
    reg [`APM_IRQ_W-1:0] irqMask_r;
    reg muteSeen_r;
    reg resetSeen_r;
    reg clkBadSeen_r;

    // ****************************************************
    // Bus decode
    // ****************************************************
    wire [7:0] regIdx;
    wire wordOk;
    wire busReq;
    wire wrNow;
    wire wrByte;
    assign regIdx = wb_adr_i[9:2];
    assign wordOk = (wb_adr_i[1:0] == 2'h0);
    assign busReq = wb_cyc_i & wb_stb_i;
    // Write lands on the edge the master samples ack
    assign wrNow = busReq & wb_ack_o & wb_we_i & wordOk;
    assign wrByte = wrNow & wb_sel_i[0];

    wire wrDir;
    wire wrSel1;
    wire wrSel2;
    wire wrRoute;
    wire wrVal;
    wire wrInv;
    wire wrStat;
    wire wrMask;
    assign wrDir = wrByte & regHit(regIdx, `APM_IDX_PIN_DIR);
    assign wrSel1 = wrByte & regHit(regIdx, `APM_IDX_PIN1_SEL);
    assign wrSel2 = wrByte & regHit(regIdx, `APM_IDX_PIN2_SEL);
    assign wrRoute = wrByte & regHit(regIdx, `APM_IDX_IN_ROUTE);
    assign wrVal = wrByte & regHit(regIdx, `APM_IDX_OUT_VAL);
    assign wrInv = wrByte & regHit(regIdx, `APM_IDX_OUT_INV);
    assign wrStat = wrByte & regHit(regIdx, `APM_IDX_IRQ_STAT);
    assign wrMask = wrByte & regHit(regIdx, `APM_IDX_IRQ_MASK);

    // ****************************************************
    // Input routing
    // ****************************************************
    wire [1:0] misoSrc;
    wire [1:0] syncSrc;
    wire [1:0] rstSrc;
    wire [1:0] muteSrc;
    assign misoSrc = inRoute_r[`APM_MISO_HI:`APM_MISO_LO];
    assign syncSrc = inRoute_r[`APM_SYNC_HI:`APM_SYNC_LO];
    assign rstSrc = inRoute_r[`APM_RSTSRC_HI:`APM_RSTSRC_LO];
    assign muteSrc = inRoute_r[`APM_MUTESRC_HI:`APM_MUTESRC_LO];

    wire misoNxt;
    wire syncNxt;
    wire rstLvl_n;
    wire muteLvl_n;
    assign misoNxt = routePick(misoSrc, pinIn, 1'b0);
    assign syncNxt = routePick(syncSrc, pinIn, 1'b0);
    // Unrouted reset and mute sit at their inactive high level
    assign rstLvl_n = routePick(rstSrc, pinIn, 1'b1);
    assign muteLvl_n = routePick(muteSrc, pinIn, 1'b1);

    // ****************************************************
    // Pin reset exclusion
    // ****************************************************
    // Held low, the pin clears setup on every clock
    wire pinReset;
    assign pinReset = ~rstLvl_n;

    // Bits of the reset pin survive a pin-triggered reset
    reg [7:0] keepMask;
    always @* begin
        keepMask = 8'h00;
        case (rstSrc)
            `APM_ROUTE_PIN0: keepMask = 8'h01;
            `APM_ROUTE_PIN1: keepMask = 8'h02;
            `APM_ROUTE_PIN2: keepMask = 8'h04;
            default: keepMask = 8'h00;
        endcase
    end

    wire keepSel1;
    wire keepSel2;
    assign keepSel1 = (rstSrc == `APM_ROUTE_PIN1);
    assign keepSel2 = (rstSrc == `APM_ROUTE_PIN2);

    // ****************************************************
    // Configuration registers
    // ****************************************************
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pinDir_r <= `APM_RST_BYTE;
            pin1Sel_r <= `APM_RST_BYTE;
            pin2Sel_r <= `APM_RST_BYTE;
            inRoute_r <= `APM_RST_BYTE;
            outVal_r <= `APM_RST_BYTE;
            outInv_r <= `APM_RST_BYTE;
            irqMask_r <= {`APM_IRQ_W{1'b0}};
        end else if (pinReset) begin
            // Routing stays, else the reset pin would let go
            pinDir_r <= pinDir_r & keepMask;
            outVal_r <= outVal_r & keepMask;
            outInv_r <= outInv_r & keepMask;
            if (!keepSel1) begin
                pin1Sel_r <= `APM_RST_BYTE;
            end
            if (!keepSel2) begin
                pin2Sel_r <= `APM_RST_BYTE;
            end
        end else begin
            if (wrDir) begin
                pinDir_r <= wb_dat_i[7:0];
            end
            if (wrSel1) begin
                pin1Sel_r <= wb_dat_i[7:0];
            end
            if (wrSel2) begin
                pin2Sel_r <= wb_dat_i[7:0];
            end
            if (wrRoute) begin
                inRoute_r <= wb_dat_i[7:0];
            end
            if (wrVal) begin
                outVal_r <= wb_dat_i[7:0];
            end
            if (wrInv) begin
                outInv_r <= wb_dat_i[7:0];
            end
            if (wrMask) begin
                irqMask_r <= wb_dat_i[`APM_IRQ_W-1:0];
            end
        end
    end

    // ****************************************************
    // Pin drive
    // ****************************************************
    wire clkBad;
    wire [2:0] pinRaw;
    assign clkBad = clockError | clockMissing;
    // Pin 0 has no selector here; it carries its value bit
    assign pinRaw[0] = outVal_r[0];
    assign pinRaw[1] = pinFunc(pin1Sel_r[`APM_SEL_HI:`APM_SEL_LO],
        outVal_r[1], autoMuteLeft, autoMuteRight, clkBad,
        warning_out_n, serial_audio_out, spiClk, spiMosi);
    assign pinRaw[2] = pinFunc(pin2Sel_r[`APM_SEL_HI:`APM_SEL_LO],
        outVal_r[2], autoMuteLeft, autoMuteRight, clkBad,
        warning_out_n, serial_audio_out, spiClk, spiMosi);

    // One flop at each pin, so mux switching cannot glitch it
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pinOut_r <= 3'h0;
            pinOe_r <= 3'h0;
        end else begin
            pinOut_r <= pinRaw ^ outInv_r[2:0];
            pinOe_r <= pinDir_r[2:0];
        end
    end

    // ****************************************************
    // Routed inputs toward the core
    // ****************************************************
    // Routed levels read the pin whatever its direction
    // Limitation: a driving pin sees its own output level
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            spiMisoIn_r <= 1'b0;
            phaseSyncIn_r <= 1'b0;
            extReset_r <= 1'b0;
            mute_in_n_r <= 1'b1;
            driverHiZ_r <= 1'b0;
            switchStop_r <= 1'b0;
        end else begin
            spiMisoIn_r <= misoNxt;
            phaseSyncIn_r <= syncNxt;
            extReset_r <= pinReset;
            mute_in_n_r <= muteLvl_n;
            driverHiZ_r <= ~muteLvl_n;
            switchStop_r <= ~muteLvl_n;
        end
    end

    // ****************************************************
    // Interrupt events
    // ****************************************************
    wire [`APM_IRQ_W-1:0] evt;
    wire [`APM_IRQ_W-1:0] clrBits;
    wire [`APM_IRQ_W-1:0] statNxt;
    assign evt[`APM_IRQ_MUTE] = ~muteLvl_n & ~muteSeen_r;
    assign evt[`APM_IRQ_RESET] = pinReset & ~resetSeen_r;
    assign evt[`APM_IRQ_CLKBAD] = clkBad & ~clkBadSeen_r;
    assign clrBits = wrStat ? wb_dat_i[`APM_IRQ_W-1:0]
                            : {`APM_IRQ_W{1'b0}};
    // New event beats a clear in the same cycle
    assign statNxt = (irqStat_r & ~clrBits) | evt;

    // Seen flops turn levels into events; a held level sets once
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            muteSeen_r <= 1'b0;
            resetSeen_r <= 1'b0;
            clkBadSeen_r <= 1'b0;
            irqStat_r <= {`APM_IRQ_W{1'b0}};
            irq_r <= 1'b0;
        end else begin
            muteSeen_r <= ~muteLvl_n;
            resetSeen_r <= pinReset;
            clkBadSeen_r <= clkBad;
            irqStat_r <= statNxt;
            // Built from next status so irq lines up with status
            irq_r <= |(statNxt & irqMask_r);
        end
    end

    // ****************************************************
    // Bus answer
    // ****************************************************
    reg [7:0] rdByte;
    always @* begin
        rdByte = 8'h00;
        case (regIdx)
            `APM_IDX_PIN_DIR: rdByte = pinDir_r;
            `APM_IDX_PIN1_SEL: rdByte = pin1Sel_r;
            `APM_IDX_PIN2_SEL: rdByte = pin2Sel_r;
            `APM_IDX_IN_ROUTE: rdByte = inRoute_r;
            `APM_IDX_OUT_VAL: rdByte = outVal_r;
            `APM_IDX_OUT_INV: rdByte = outInv_r;
            `APM_IDX_IDENT: rdByte = IDENT_VALUE;
            `APM_IDX_IRQ_STAT: rdByte = {5'h00, irqStat_r};
            `APM_IDX_IRQ_MASK: rdByte = {5'h00, irqMask_r};
            default: rdByte = 8'h00;
        endcase
        if (!wordOk) begin
            rdByte = 8'h00;
        end
    end

    // Every cycle answered in one clock, unmapped reads give zero
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            // Ack drops after one cycle even if strobe is held
            wb_ack_o <= busReq & ~wb_ack_o;
            if (busReq & ~wb_ack_o & ~wb_we_i) begin
                wb_dat_o <= {24'h00_0000, rdByte};
            end else begin
                wb_dat_o <= 32'h0000_0000;
            end
        end
    end

endmodule // apm_pin_mux

// >>> apm_pin_mux_monitor.sv
// Port-level concurrent checks for the general pin mux
`timescale 1ns/1ns
module apm_pin_mux_monitor #(
    parameter ADR_W = 10,
    // Arbitrary identification value, handed down by the bind
    parameter [7:0] IDENT_VALUE = 8'h5a
) (
    input wire clk_sys,
    input wire rst_n,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [ADR_W-1:0] wb_adr_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire [2:0] pinIn,
    input wire spiMisoIn_r,
    input wire phaseSyncIn_r,
    input wire extReset_r,
    input wire mute_in_n_r,
    input wire driverHiZ_r,
    input wire switchStop_r,
    input wire irq_r
);
    // Identification byte sits at word index 0x67
    localparam [ADR_W-1:0] IDENT_ADR = 10'h19c;
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // ****************************************
    // Bus answer and routed inputs
    // ****************************************
    AST_ACK_ONE: assert property (req |=> wb_ack_o)
        else $error("request not answered after one cycle");
    AST_ACK_PULSE: assert property ($rose(wb_ack_o) |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    AST_IDENT_READ: assert property (req && !wb_we_i &&
        wb_adr_i == IDENT_ADR |=> wb_dat_o == {24'h0, IDENT_VALUE})
        else $error("identification read wrong");
    AST_MUTE_HIZ: assert property (driverHiZ_r == !mute_in_n_r)
        else $error("driver high impedance not following mute");
    AST_MUTE_STOP: assert property (switchStop_r == driverHiZ_r)
        else $error("switching stop not following mute");
    AST_MUTE_SRC: assert property (
        !mute_in_n_r |-> $past(pinIn) != 3'h7)
        else $error("mute active with every pin high");
    AST_RST_SRC: assert property (
        extReset_r |-> $past(pinIn) != 3'h7)
        else $error("pin reset active with every pin high");
    AST_MISO_SRC: assert property (
        spiMisoIn_r |-> $past(pinIn) != 3'h0)
        else $error("data-in high with every pin low");
    AST_SYNC_SRC: assert property (
        phaseSyncIn_r |-> $past(pinIn) != 3'h0)
        else $error("phase sync high with every pin low");
    COV_WRITE: cover property (req && wb_we_i ##1 wb_ack_o);
    COV_IRQ: cover property ($rose(irq_r));
    COV_PIN_RST: cover property ($rose(extReset_r));
    COV_MUTE: cover property ($rose(driverHiZ_r));
endmodule // apm_pin_mux_monitor

// >>> apm_pin_mux_board.sv
// Board-side model that reads or drives the three general pins
`timescale 1ns/1ns
module apm_pin_mux_board (
    input wire [2:0] pinOut,
    input wire [2:0] pinOe,
    input wire [2:0] drvEn,
    input wire [2:0] drvVal,
    output wire [2:0] pinIn
);
    // Undriven pins float high through board pull-ups
    assign pinIn = (pinOe & pinOut) | (~pinOe & drvEn & drvVal) |
        (~pinOe & ~drvEn);
endmodule // apm_pin_mux_board

// >>> apm_pin_mux_tb.sv
// Self-checking bench for the general pin mux
`timescale 1ns/1ns
module apm_pin_mux_tb;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [9:0] adr = 10'h0;
    logic [31:0] wdat = 32'h0;
    logic [7:0] src = 8'h0, r, e;
    logic [2:0] drvEn = 3'h0, drvVal = 3'h0;
    wire [31:0] rdat;
    wire [2:0] pinIn, pinOut, pinOe;
    wire ack, misoIn, syncIn, extRst, muteN, hiZ, swStop, irq;
    wire [7:0] pOut8 = {5'h0, pinOut};
    wire [7:0] side = {misoIn, syncIn, muteN, hiZ, swStop, irq, 2'h0};
    int failures = 0, n_checks = 0;
    // Selector, sources {amL,amR,clkErr,clkMiss,warnN,sdo,sck,mosi}, level
    logic [12:0] rows [24] = '{13'h01fe, 13'h03fe, 13'h0401, 13'h0700,
        13'h0781, 13'h0901, 13'h08fe, 13'h0a81, 13'h0b7e, 13'h0c41,
        13'h0c21, 13'h0d9e, 13'h0ffe, 13'h1011, 13'h11ee, 13'h1209,
        13'h13f6, 13'h1605, 13'h17fa, 13'h19fe, 13'h1a03, 13'h1bfc,
        13'h1dfe, 13'h1ffe};
    always #2 clk_sys = ~clk_sys;
    // Arbitrary identification value
    apm_pin_mux #(.IDENT_VALUE(8'h3c)) dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .pinIn(pinIn), .pinOut_r(pinOut),
        .pinOe_r(pinOe), .autoMuteLeft(src[7]), .autoMuteRight(src[6]),
        .clockError(src[5]), .clockMissing(src[4]), .warning_out_n(src[3]),
        .serial_audio_out(src[2]), .spiClk(src[1]), .spiMosi(src[0]),
        .spiMisoIn_r(misoIn), .phaseSyncIn_r(syncIn), .extReset_r(extRst),
        .mute_in_n_r(muteN), .driverHiZ_r(hiZ), .switchStop_r(swStop),
        .irq_r(irq));
    apm_pin_mux_board board (.pinOut(pinOut), .pinOe(pinOe), .drvEn(drvEn),
        .drvVal(drvVal), .pinIn(pinIn));
    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys);
    endtask
    // Waits for ack however long; only the watchdog ends a hang
    task automatic xfer(input bit w, input [7:0] i, input [7:0] d);
        @(posedge clk_sys);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, i, 2'b00, 24'h0, d};
        do begin
            @(posedge clk_sys);
        end while (ack !== 1'b1);
        r = rdat[7:0];
        {cyc, stb, we} <= 3'h0;
    endtask
    task automatic wr(input [7:0] i, input [7:0] d);
        xfer(1'b1, i, d);
    endtask
    task automatic chk(input [7:0] g, input [7:0] x);
        n_checks++;
        if (g !== x) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task automatic rdc(input [7:0] i, input [7:0] x);
        xfer(1'b0, i, 8'h0);
        chk(r, x);
    endtask
    task automatic report_and_stop;
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        tick(16);
        rst_n <= 1'b1;
        for (int k = 8'h60; k <= 8'h68; k++) begin
            e = (k == 8'h67) ? 8'h3c : 8'h00;
            rdc(k[7:0], e);
        end
        wr(8'h67, 8'hff);
        rdc(8'h67, 8'h3c);
        $display("test reset values done");
        wr(8'h60, 8'h07);
        wr(8'h65, 8'h06);
        tick(2);
        chk({5'h0, pinOe}, 8'h07);
        foreach (rows[k]) begin
            wr(8'h62, {4'h0, rows[k][12:9]});
            wr(8'h63, {4'h0, rows[k][12:9]});
            src <= rows[k][8:1];
            e = {5'h0, rows[k][0], rows[k][0], 1'b0};
            tick(3);
            chk(pOut8, e);
        end
        $display("test selector codes done");
        wr(8'h62, 8'h02);
        wr(8'h63, 8'h02);
        wr(8'h65, 8'h05);
        tick(2);
        chk(pOut8, 8'h05);
        wr(8'h66, 8'h07);
        tick(2);
        chk(pOut8, 8'h02);
        wr(8'h62, 8'h00);
        wr(8'h63, 8'h00);
        tick(2);
        chk(pOut8, 8'h06);
        wr(8'h66, 8'h00);
        $display("test output polarity done");
        // Pins become inputs so the board can drive them
        wr(8'h60, 8'h00);
        wr(8'h71, 8'h01);
        wr(8'h64, 8'he1);
        drvEn <= 3'h7;
        drvVal <= 3'h4;
        tick(4);
        chk(side, 8'h9c);
        drvVal <= 3'h3;
        tick(4);
        chk(side, 8'h64);
        wr(8'h70, 8'h07);
        tick(2);
        chk(side, 8'h60);
        wr(8'h71, 8'h00);
        drvVal <= 3'h2;
        tick(4);
        chk(side, 8'h58);
        rdc(8'h70, 8'h01);
        wr(8'h70, 8'h01);
        drvVal <= 3'h7;
        $display("test input routing done");
        wr(8'h64, 8'h08);
        wr(8'h60, 8'h05);
        wr(8'h65, 8'h07);
        wr(8'h62, 8'h02);
        wr(8'h63, 8'h02);
        drvVal <= 3'h5;
        tick(3);
        chk({7'h0, extRst}, 8'h01);
        wr(8'h65, 8'h00);
        drvVal <= 3'h7;
        tick(3);
        chk({7'h0, extRst}, 8'h00);
        rdc(8'h60, 8'h00);
        rdc(8'h65, 8'h02);
        rdc(8'h62, 8'h02);
        rdc(8'h63, 8'h00);
        rdc(8'h64, 8'h08);
        $display("test pin reset done");
        rst_n <= 1'b0;
        tick(2);
        rst_n <= 1'b1;
        rdc(8'h64, 8'h00);
        chk(pOut8, 8'h00);
        chk({5'h0, pinOe}, 8'h00);
        chk(side, 8'h20);
        $display("test second reset done");
        report_and_stop;
    end
    // Whole run needs about four hundred cycles
    initial begin
        tick(5000);
        failures++;
        report_and_stop;
    end
endmodule // apm_pin_mux_tb
bind apm_pin_mux apm_pin_mux_monitor #(.ADR_W(ADR_W),
    .IDENT_VALUE(IDENT_VALUE)) mon (.clk_sys(clk_sys), .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .pinIn(pinIn), .spiMisoIn_r(spiMisoIn_r), .phaseSyncIn_r(phaseSyncIn_r),
    .extReset_r(extReset_r), .mute_in_n_r(mute_in_n_r),
    .driverHiZ_r(driverHiZ_r), .switchStop_r(switchStop_r), .irq_r(irq_r));
